// file: hdl/oebd_bank.sv
// descriptor bank end: per-endpoint descriptor bytes shared by firmware and engine
`timescale 1ns/1ns
module oebd_bank
   import oebd_pkg::*;
#(
   parameter int unsigned NUM_EP = OEBD_NUM_EP
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   oebd_if.bank dsc,
   input wire logic [5:0] sw_addr,
   input wire logic [7:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [7:0] sw_rdata
);
   typedef struct packed {
      logic [NUM_EP-1:0][7:0][7:0] mem;
      logic [7:0] sw_rdata;
      logic [7:0] eng_rdata;
   } oebd_bank_s;
   oebd_bank_s s_r, s_nxt;
   // software address: endpoint index (1..NUM_EP) in bits 5..3, offset in bits 2..0
   function automatic logic ep_hit(input logic [2:0] epn);
      ep_hit = (epn != 3'h0) && (epn <= 3'(NUM_EP));
   endfunction
   function automatic logic [7:0] clean(input logic [2:0] off, input logic [7:0] d);
      clean = (off == OEBD_OFF_SIZE) ? (d & OEBD_SIZE_RSV_MASK) : d;
   endfunction
   always_comb begin
      logic [2:0] sep;
      logic [2:0] soff;
      logic [1:0] sidx;
      sep = sw_addr[5:3];
      soff = sw_addr[2:0];
      sidx = 2'(sep - 3'h1);
      s_nxt = s_r;
      s_nxt.sw_rdata = 8'h00;
      // the engine byte holds until the next read, so the engine may take it late
      if (dsc.rd) begin
         s_nxt.eng_rdata = s_r.mem[dsc.ep][dsc.off];
      end
      if (sw_rd && ep_hit(sep)) begin
         s_nxt.sw_rdata = s_r.mem[sidx][soff];
      end
      // software writes first; an engine write in the same cycle wins so the flag set is not lost
      if (sw_wr && ep_hit(sep)) begin
         s_nxt.mem[sidx][soff] = clean(soff, sw_wdata);
      end
      if (dsc.wr && (dsc.off == OEBD_OFF_X_COUNT || dsc.off == OEBD_OFF_Y_COUNT)) begin
         s_nxt.mem[dsc.ep][dsc.off] = dsc.wdata;
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign dsc.rdata = s_r.eng_rdata;
   assign sw_rdata = s_r.sw_rdata;
endmodule

// file: hdl/oebd_engine.sv
// packet buffer engine end: services host OUT packets against the descriptors
`timescale 1ns/1ns
module oebd_engine
   import oebd_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   oebd_if.engine dsc,
   input wire logic out_req,
   input wire logic [1:0] out_ep,
   input wire logic out_use_y,
   input wire logic [6:0] out_len,
   output logic out_ack,
   output logic out_nak,
   output logic [10:0] out_start_addr
);
   typedef struct packed {
      oebd_state_e st;
      logic [1:0] ep;
      logic use_y;
      logic [6:0] len;
      logic [2:0] off;
      logic rd;
      logic wr;
      logic [7:0] wdata;
      logic ack;
      logic nak;
      oebd_addr_t addr;
      logic pend;
   } oebd_eng_s;
   oebd_eng_s s_r, s_nxt;
   always_comb begin
      s_nxt = s_r;
      s_nxt.rd = 1'b0;
      s_nxt.wr = 1'b0;
      s_nxt.ack = 1'b0;
      s_nxt.nak = 1'b0;
      s_nxt.pend = 1'b0;
      unique case (s_r.st)
         OEBD_IDLE: begin
            if (out_req) begin
               s_nxt.ep = out_ep;
               s_nxt.use_y = out_use_y;
               s_nxt.len = out_len;
               s_nxt.off = OEBD_OFF_CFG;
               s_nxt.rd = 1'b1;
               s_nxt.pend = 1'b1;
               s_nxt.st = OEBD_RD_CNT;
            end
         end
         OEBD_RD_CNT: begin
            // the bank answer is registered, so every read state lets one cycle pass first
            if (!s_r.pend) begin
               if (!dsc.rdata[OEBD_ENABLE_BIT]) begin
                  s_nxt.nak = 1'b1;
                  s_nxt.st = OEBD_IDLE;
               end else begin
                  s_nxt.off = s_r.use_y ? OEBD_OFF_Y_COUNT : OEBD_OFF_X_COUNT;
                  s_nxt.rd = 1'b1;
                  s_nxt.pend = 1'b1;
                  s_nxt.st = OEBD_WAIT;
               end
            end
         end
         OEBD_WAIT: begin
            if (!s_r.pend) begin
               if (dsc.rdata[OEBD_FLAG_BIT]) begin
                  s_nxt.nak = 1'b1;
                  s_nxt.st = OEBD_IDLE;
               end else begin
                  // empty buffer accepts the packet
                  s_nxt.off = s_r.use_y ? OEBD_OFF_Y_BASE : OEBD_OFF_X_BASE;
                  s_nxt.rd = 1'b1;
                  s_nxt.pend = 1'b1;
                  s_nxt.st = OEBD_WR_CNT;
               end
            end
         end
         OEBD_WR_CNT: begin
            if (!s_r.pend) begin
               // base is only read, never written back
               s_nxt.addr = {dsc.rdata, OEBD_ALIGN_ZEROS};
               s_nxt.off = s_r.use_y ? OEBD_OFF_Y_COUNT : OEBD_OFF_X_COUNT;
               s_nxt.wdata = {1'b1, s_r.len};
               s_nxt.wr = 1'b1;
               s_nxt.ack = 1'b1;
               s_nxt.st = OEBD_IDLE;
            end
         end
      endcase
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign dsc.ep = s_r.ep;
   assign dsc.off = s_r.off;
   assign dsc.rd = s_r.rd;
   assign dsc.wr = s_r.wr;
   assign dsc.wdata = s_r.wdata;
   assign out_ack = s_r.ack;
   assign out_nak = s_r.nak;
   assign out_start_addr = s_r.addr;
endmodule

// file: hdl/oebd_if.sv
// interface: descriptor access between firmware-side bank and packet buffer engine
`timescale 1ns/1ns
interface oebd_if;
   import oebd_pkg::*;
   logic [1:0] ep;
   logic [2:0] off;
   logic rd;
   logic wr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport bank (input ep, off, rd, wr, wdata, output rdata);
   modport engine (output ep, off, rd, wr, wdata, input rdata);
endinterface

// file: hdl/oebd_pkg.sv
// package: descriptor offsets, field layout and sizes for output endpoint descriptors
package oebd_pkg;
   localparam int unsigned OEBD_NUM_EP = 3;
   localparam logic [2:0] OEBD_OFF_CFG = 3'h0;
   localparam logic [2:0] OEBD_OFF_X_BASE = 3'h1;
   localparam logic [2:0] OEBD_OFF_X_COUNT = 3'h2;
   localparam logic [2:0] OEBD_OFF_Y_BASE = 3'h5;
   localparam logic [2:0] OEBD_OFF_Y_COUNT = 3'h6;
   localparam logic [2:0] OEBD_OFF_SIZE = 3'h7;
   localparam int unsigned OEBD_FLAG_BIT = 7;
   localparam int unsigned OEBD_ENABLE_BIT = 7;
   localparam logic [6:0] OEBD_MAX_COUNT = 7'h40;
   localparam logic [2:0] OEBD_ALIGN_ZEROS = 3'h0;
   localparam logic [7:0] OEBD_SIZE_RSV_MASK = 8'h7f;
   typedef logic [10:0] oebd_addr_t;
   typedef enum logic [1:0] {
      OEBD_IDLE = 2'b00,
      OEBD_RD_CNT = 2'b01,
      OEBD_WAIT = 2'b10,
      OEBD_WR_CNT = 2'b11
   } oebd_state_e;
endpackage

// file: test/oebd_asserts.sv
// checker: descriptor traffic rules on the bank/engine interface
`timescale 1ns/1ns
module oebd_asserts (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [1:0] ep,
   input wire logic [2:0] off,
   input wire logic rd,
   input wire logic wr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_ep_range: assert property ((rd || wr) |-> ep < 2'h3)
      else $error("bad endpoint");
   a_wr_flag: assert property (wr |-> wdata[7])
      else $error("flag not set");
   a_len_range: assert property (wr |-> wdata[6:0] <= 7'h40)
      else $error("count over max");
   a_base_kept: assert property (wr |-> off inside {3'h2, 3'h6})
      else $error("write off a count byte");
   a_base_read: assert property (wr |-> $past(rd, 2) && $past(off, 2) == off - 3'h1)
      else $error("base not read");
   a_count_read: assert property (wr |-> $past(rd, 4) && $past(off, 4) == off)
      else $error("count not read");
   a_cfg_first: assert property ((rd && off[1]) |-> $past(rd, 2) && $past(off, 2) == 3'h0)
      else $error("enable not read");
   a_flag_nak: assert property ((rd && off[1]) ##1 rdata[7] |-> ##1 !wr [*3])
      else $error("full buffer written");
   a_off_no_wr: assert property ((rd && off == 3'h0) ##1 !rdata[7] |-> ##1 !wr [*5])
      else $error("disabled endpoint written");
endmodule

// file: test/tb_top.sv
// bench: bank and engine joined, driven from both user sides
`timescale 1ns/1ns
module tb_top;
   logic core_clk = 1'b0, rst_n = 1'b0, sw_wr = 1'b0, sw_rd = 1'b0, out_req = 1'b0;
   logic out_use_y = 1'b0, out_ack, out_nak;
   logic [5:0] sw_addr = 6'h00;
   logic [7:0] sw_wdata = 8'h00, sw_rdata;
   logic [1:0] out_ep = 2'h0;
   logic [6:0] out_len = 7'h00;
   logic [10:0] out_start_addr;
   int failures = 0, total_checks = 0;
   // rows: address, byte written, byte read back
   logic [21:0] rows [4] = '{{6'h0a, 8'h40, 8'h40}, {6'h1e, 8'hc0, 8'hc0},
      {6'h0f, 8'hc0, 8'h40}, {6'h02, 8'h55, 8'h00}};
   oebd_if dsc ();
   oebd_bank oebd_bank_inst (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .dsc(dsc),
      .sw_addr(sw_addr),
      .sw_wdata(sw_wdata),
      .sw_wr(sw_wr),
      .sw_rd(sw_rd),
      .sw_rdata(sw_rdata)
   );
   oebd_engine oebd_engine_inst (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .dsc(dsc),
      .out_req(out_req),
      .out_ep(out_ep),
      .out_use_y(out_use_y),
      .out_len(out_len),
      .out_ack(out_ack),
      .out_nak(out_nak),
      .out_start_addr(out_start_addr)
   );
   oebd_asserts oebd_asserts_inst (.core_clk(core_clk), .rst_n(rst_n), .ep(dsc.ep), .off(dsc.off),
      .rd(dsc.rd), .wr(dsc.wr), .wdata(dsc.wdata), .rdata(dsc.rdata));
   task automatic chk(input string n, input logic [10:0] e, input logic [10:0] s);
      total_checks++;
      if (s !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   // sw_write, sw_read and pkt each wait an edge first, so a strobe never drops and rises in one step
   task automatic sw_write(input logic [5:0] a, input logic [7:0] d);
      @(posedge core_clk);
      {sw_addr, sw_wdata, sw_wr} <= {a, d, 1'b1};
      @(posedge core_clk);
      sw_wr <= 1'b0;
   endtask
   task automatic sw_read(input logic [5:0] a, input logic [7:0] e);
      @(posedge core_clk);
      {sw_addr, sw_rd} <= {a, 1'b1};
      @(posedge core_clk);
      sw_rd <= 1'b0;
      #1 chk("sw_rdata", {3'h0, e}, {3'h0, sw_rdata});
   endtask
   task automatic pkt(input logic [9:0] q, input logic [1:0] an, input logic [10:0] lt, sa);
      int i;
      @(posedge core_clk);
      {out_ep, out_use_y, out_len, out_req} <= {q, 1'b1};
      @(posedge core_clk);
      out_req <= 1'b0;
      for (i = 2; i < 10; i++) begin
         @(posedge core_clk);
         #1;
         if (out_ack === 1'b1 || out_nak === 1'b1) break;
      end
      chk("ack_nak", {9'h0, an}, {9'h0, out_ack, out_nak});
      chk("latency", lt, 11'(i));
      chk("start_addr", sa, out_start_addr);
   endtask
   task automatic end_of_test();
      if (failures == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      repeat (2000) @(posedge core_clk);
      failures++;
      end_of_test();
   end
   initial begin
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      #1 chk("rst_addr", 11'h0, out_start_addr);
      chk("rst_ack_nak", 11'h0, {9'h0, out_ack, out_nak});
      foreach (rows[k]) begin
         sw_write(rows[k][21:16], rows[k][15:8]);
         sw_read(rows[k][21:16], rows[k][7:0]);
      end
      pkt({2'h0, 1'b1, 7'h00}, 2'b01, 11'h3, 11'h0);
      sw_write(6'h08, 8'h80);
      sw_write(6'h0d, 8'h12);
      pkt({2'h0, 1'b1, 7'h40}, 2'b10, 11'h7, 11'h090);
      sw_read(6'h0e, 8'hc0);
      sw_read(6'h0d, 8'h12);
      pkt({2'h0, 1'b1, 7'h05}, 2'b01, 11'h5, 11'h090);
      sw_write(6'h0e, 8'h00);
      pkt({2'h0, 1'b1, 7'h05}, 2'b10, 11'h7, 11'h090);
      sw_read(6'h0e, 8'h85);
      sw_write(6'h18, 8'h80);
      sw_write(6'h19, 8'hff);
      pkt({2'h2, 1'b0, 7'h00}, 2'b10, 11'h7, 11'h7f8);
      sw_read(6'h1a, 8'h80);
      // reset in mid-run clears the descriptors and the engine outputs
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      #1 chk("rst2_addr", 11'h0, out_start_addr);
      chk("rst2_ack_nak", 11'h0, {9'h0, out_ack, out_nak});
      sw_read(6'h19, 8'h00);
      pkt({2'h2, 1'b0, 7'h00}, 2'b01, 11'h3, 11'h0);
      end_of_test();
   end
endmodule
